// ==== ppid_top.sv ====
// pin interrupt detection for two four-pin port groups behind an apb slave
// assumes pins already synchronous to core_clk; one clock, asynchronous reset
// Functional notes
// - low four pins of both ports act as external interrupt inputs
// - enabled pin interrupt acts as wake-up from wait and retained stop
// - per-pin enable bit; only enabled pins are detected
// - mode bit per port picks edge-only or edge-and-level detection
// - per-pin polarity: falling/low versus rising/high
// - edges detected on bus clock, only after deasserted level seen
// - falling edge: sampled high, then low next cycle
// - rising edge: sampled low, then high next cycle
// - edge-only mode: valid edge on enabled pin sets port flag
// - flag and port interrupt enable raise the processor request
// - writing one to clear bit clears flag in edge-only mode
// - edge-and-level mode: edge or asserted level sets the flag
// - level mode clear works only when all enabled pins deasserted
// - in level mode, flag stays set if an enabled pin is asserted at clear
`timescale 1ns/1ns
`include "ppid_cfg.svh"
`default_nettype none

module ppid_top #(
    parameter int NPORT = 2,
    parameter int NPIN  = 4
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NPIN-1:0]   pin_a,
    input  wire logic [NPIN-1:0]   pin_b,
    output logic      [NPORT-1:0]  port_irq_req,
    output logic                   wake_req,
    output logic                   irq
);
    logic                   rst_s1_r;
    logic                   rst_n_r;
    ppid_pkg::ppid_apb_req_t req;
    ppid_pkg::ppid_port_cfg_t cfg_r [NPORT];
    logic [NPIN-1:0]        pin_now   [NPORT];
    logic [NPIN-1:0]        prev_r    [NPORT];
    logic [NPIN-1:0]        armed_r   [NPORT];
    logic [NPIN-1:0]        asserted  [NPORT];
    logic [NPORT-1:0]       edge_hit;
    logic [NPORT-1:0]       lvl_hit;
    logic [NPORT-1:0]       set_ev;
    logic [NPORT-1:0]       ack_wr;
    logic [NPORT-1:0]       clr_ok;
    logic [NPORT-1:0]       flag_r;
    logic [NPORT-1:0]       ev_stat_r;
    logic [NPORT-1:0]       ev_en_r;
    logic [NPORT-1:0]       ev_clr;
    logic                   wr_acc;
    logic                   addr_ok;
    logic [31:0]            rdata_nxt;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    assign req     = '{psel, penable, pwrite, paddr, pwdata};
    assign pready  = 1'b1;
    assign wr_acc  = req.psel && req.penable && req.pwrite;
    assign pin_now[0] = pin_a;
    assign pin_now[1] = pin_b;

    // per-port detection
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            // polarity bit 1 means rising/high
            asserted[p] = ~(pin_now[p] ^ cfg_r[p].polarity) & cfg_r[p].pin_en;
            // armed only once the deasserted level has been seen
            edge_hit[p] = |(asserted[p] & armed_r[p]
                           & (prev_r[p] ^ pin_now[p]));
            lvl_hit[p]  = cfg_r[p].mode_lvl && (|asserted[p]);
            set_ev[p]   = edge_hit[p] || lvl_hit[p];
            clr_ok[p]   = !cfg_r[p].mode_lvl || !(|asserted[p]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int p = 0; p < NPORT; p++) begin
                prev_r[p]  <= '0;
                armed_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                prev_r[p]  <= pin_now[p];
                // arm where enabled and deasserted, disarm when disabled
                armed_r[p] <= cfg_r[p].pin_en & (armed_r[p] | ~asserted[p]);
            end
        end
    end

    // port flag: set wins over acknowledge
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_r <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (set_ev[p]) begin
                    flag_r[p] <= 1'b1;
                end else if (ack_wr[p] && clr_ok[p]) begin
                    flag_r[p] <= 1'b0;
                end
            end
        end
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_req
        assign port_irq_req[p] = flag_r[p] && cfg_r[p].irq_en;
    end
    // flag is live without a clock gate, so it doubles as wake-up
    assign wake_req = |flag_r;

    // summary status of port events, sticky, for a unified interrupt line
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_stat_r <= '0;
        end else begin
            ev_stat_r <= set_ev | (ev_stat_r & ~ev_clr);
        end
    end
    assign irq = |(ev_stat_r & ev_en_r);

    // write decode
    always_comb begin
        ack_wr = '0;
        ev_clr = '0;
        if (wr_acc && req.paddr == `PPID_OFF_SC_A) begin
            ack_wr[0] = req.pwdata[`PPID_SC_ACK_BIT];
        end else if (wr_acc && req.paddr == `PPID_OFF_SC_B) begin
            ack_wr[1] = req.pwdata[`PPID_SC_ACK_BIT];
        end else if (wr_acc && req.paddr == `PPID_OFF_ICLR) begin
            ev_clr = req.pwdata[NPORT-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int p = 0; p < NPORT; p++) begin
                cfg_r[p].pin_en   <= `PPID_PS_RESET;
                cfg_r[p].polarity <= `PPID_ES_RESET;
                cfg_r[p].mode_lvl <= 1'b0;
                cfg_r[p].irq_en   <= 1'b0;
            end
            ev_en_r <= '0;
        end else if (wr_acc) begin
            if (req.paddr == `PPID_OFF_SC_A) begin
                cfg_r[0].mode_lvl <= req.pwdata[`PPID_SC_MODE_BIT];
                cfg_r[0].irq_en   <= req.pwdata[`PPID_SC_IE_BIT];
            end else if (req.paddr == `PPID_OFF_PS_A) begin
                cfg_r[0].pin_en   <= req.pwdata[NPIN-1:0];
            end else if (req.paddr == `PPID_OFF_ES_A) begin
                cfg_r[0].polarity <= req.pwdata[NPIN-1:0];
            end else if (req.paddr == `PPID_OFF_SC_B) begin
                cfg_r[1].mode_lvl <= req.pwdata[`PPID_SC_MODE_BIT];
                cfg_r[1].irq_en   <= req.pwdata[`PPID_SC_IE_BIT];
            end else if (req.paddr == `PPID_OFF_PS_B) begin
                cfg_r[1].pin_en   <= req.pwdata[NPIN-1:0];
            end else if (req.paddr == `PPID_OFF_ES_B) begin
                cfg_r[1].polarity <= req.pwdata[NPIN-1:0];
            end else if (req.paddr == `PPID_OFF_IEN) begin
                ev_en_r <= req.pwdata[NPORT-1:0];
            end
        end
    end

    // read decode; ack bit always reads zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        addr_ok   = 1'b1;
        if (req.paddr == `PPID_OFF_SC_A) begin
            rdata_nxt[`PPID_SC_MODE_BIT] = cfg_r[0].mode_lvl;
            rdata_nxt[`PPID_SC_IE_BIT]   = cfg_r[0].irq_en;
            rdata_nxt[`PPID_SC_FLAG_BIT] = flag_r[0];
        end else if (req.paddr == `PPID_OFF_PS_A) begin
            rdata_nxt[NPIN-1:0] = cfg_r[0].pin_en;
        end else if (req.paddr == `PPID_OFF_ES_A) begin
            rdata_nxt[NPIN-1:0] = cfg_r[0].polarity;
        end else if (req.paddr == `PPID_OFF_SC_B) begin
            rdata_nxt[`PPID_SC_MODE_BIT] = cfg_r[1].mode_lvl;
            rdata_nxt[`PPID_SC_IE_BIT]   = cfg_r[1].irq_en;
            rdata_nxt[`PPID_SC_FLAG_BIT] = flag_r[1];
        end else if (req.paddr == `PPID_OFF_PS_B) begin
            rdata_nxt[NPIN-1:0] = cfg_r[1].pin_en;
        end else if (req.paddr == `PPID_OFF_ES_B) begin
            rdata_nxt[NPIN-1:0] = cfg_r[1].polarity;
        end else if (req.paddr == `PPID_OFF_ISTAT) begin
            rdata_nxt[NPORT-1:0] = ev_stat_r;
        end else if (req.paddr == `PPID_OFF_IEN) begin
            rdata_nxt[NPORT-1:0] = ev_en_r;
        end else if (req.paddr == `PPID_OFF_ICLR) begin
            rdata_nxt = 32'h0000_0000;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // read data registered in setup so it is stable in the access phase
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata <= 32'h0000_0000;
        end else if (req.psel && !req.penable) begin
            prdata <= rdata_nxt;
        end
    end
    assign pslverr = req.psel && req.penable && !addr_ok;

    // assertions
    property p_edge_sets_flag;
        @(posedge core_clk) disable iff (!rst_n_r)
        edge_hit[0] |=> flag_r[0];
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("edge did not set flag");

    property p_fall_edge;
        @(posedge core_clk) disable iff (!rst_n_r)
        (cfg_r[0].pin_en[0] && !cfg_r[0].polarity[0] && !cfg_r[0].mode_lvl
         && armed_r[0][0] && $past(pin_a[0]) && !pin_a[0] && prev_r[0][0] == $past(pin_a[0]))
        |-> edge_hit[0];
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed");

    property p_rise_edge;
        @(posedge core_clk) disable iff (!rst_n_r)
        (cfg_r[1].pin_en[0] && cfg_r[1].polarity[0] && armed_r[1][0]
         && !prev_r[1][0] && pin_b[0]) |-> edge_hit[1];
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

    property p_disabled_pin;
        @(posedge core_clk) disable iff (!rst_n_r)
        (cfg_r[0].pin_en == 4'h0) |-> !set_ev[0];
    endproperty
    a_disabled_pin: assert property (p_disabled_pin) else $error("disabled pins raised event");

    property p_irq_req;
        @(posedge core_clk) disable iff (!rst_n_r)
        (set_ev[1] && cfg_r[1].irq_en && !wr_acc) |=> port_irq_req[1];
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("port request mismatch");

    property p_edge_clear;
        @(posedge core_clk) disable iff (!rst_n_r)
        (ack_wr[0] && !cfg_r[0].mode_lvl && !set_ev[0]) |=> !flag_r[0];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("acknowledge failed to clear");

    property p_level_hold;
        @(posedge core_clk) disable iff (!rst_n_r)
        (flag_r[1] && cfg_r[1].mode_lvl && (|asserted[1])) |=> flag_r[1];
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("flag cleared while level held");

    property p_level_sets;
        @(posedge core_clk) disable iff (!rst_n_r)
        (cfg_r[0].mode_lvl && (|asserted[0])) |=> flag_r[0];
    endproperty
    a_level_sets: assert property (p_level_sets) else $error("level did not set flag");

    property p_zero_ack;
        @(posedge core_clk) disable iff (!rst_n_r)
        (flag_r[0] && !ack_wr[0]) |=> flag_r[0];
    endproperty
    a_zero_ack: assert property (p_zero_ack) else $error("flag lost without acknowledge");

    property p_disarm;
        @(posedge core_clk) disable iff (!rst_n_r)
        (cfg_r[0].pin_en == '0) |=> (armed_r[0] == '0);
    endproperty
    a_disarm: assert property (p_disarm) else $error("disabled pin stayed armed");

    property p_level_clear;
        @(posedge core_clk) disable iff (!rst_n_r)
        (ack_wr[0] && cfg_r[0].mode_lvl && !(|asserted[0])) |=> !flag_r[0];
    endproperty
    a_level_clear: assert property (p_level_clear) else $error("level clear refused");

    property p_edge_only;
        @(posedge core_clk) disable iff (!rst_n_r)
        (!cfg_r[0].mode_lvl && !edge_hit[0]) |-> !set_ev[0];
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("level seen in edge mode");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_n_r)
        set_ev[1] |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("event gave no wake-up");

    property p_no_spurious;
        @(posedge core_clk) disable iff (!rst_n_r)
        (!flag_r[1] && !set_ev[1]) |=> !flag_r[1];
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("flag set with no event");

    property p_ack_zero;
        @(posedge core_clk) disable iff (!rst_n_r)
        (req.psel && !req.penable && req.paddr == `PPID_OFF_SC_A) |=> !prdata[`PPID_SC_ACK_BIT];
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("clear bit read as one");

    property p_stat_sticky;
        @(posedge core_clk) disable iff (!rst_n_r)
        (ev_stat_r[0] && !ev_clr[0]) |=> ev_stat_r[0];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

    property p_stat_clear;
        @(posedge core_clk) disable iff (!rst_n_r)
        (ev_clr[1] && !set_ev[1]) |=> !ev_stat_r[1];
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status bit not cleared");

    property p_unmapped;
        @(posedge core_clk) disable iff (!rst_n_r)
        (req.psel && req.penable && req.paddr > `PPID_OFF_ICLR) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    c_edge_flag: cover property (@(posedge core_clk) disable iff (!rst_n_r)
        edge_hit[0] ##1 flag_r[0]);
    c_level_block: cover property (@(posedge core_clk) disable iff (!rst_n_r)
        ack_wr[1] && !clr_ok[1]);
    c_irq: cover property (@(posedge core_clk) disable iff (!rst_n_r) irq);
    c_rise_edge: cover property (@(posedge core_clk) disable iff (!rst_n_r)
        edge_hit[1] ##1 port_irq_req[1]);
    c_level_clear: cover property (@(posedge core_clk) disable iff (!rst_n_r)
        ack_wr[0] && clr_ok[0] && cfg_r[0].mode_lvl);
endmodule // ppid_top

`default_nettype wire

// ==== ppid_cfg.svh ====
// register offsets, field positions and reset values of the pin interrupt block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef PPID_CFG_SVH
`define PPID_CFG_SVH

`define PPID_OFF_SC_A      12'h000
`define PPID_OFF_PS_A      12'h004
`define PPID_OFF_ES_A      12'h008
`define PPID_OFF_SC_B      12'h00C
`define PPID_OFF_PS_B      12'h010
`define PPID_OFF_ES_B      12'h014
`define PPID_OFF_ISTAT     12'h018
`define PPID_OFF_IEN       12'h01C
`define PPID_OFF_ICLR      12'h020

`define PPID_SC_MODE_BIT   0
`define PPID_SC_IE_BIT     1
`define PPID_SC_ACK_BIT    2
`define PPID_SC_FLAG_BIT   3

`define PPID_ES_RESET      4'h0
`define PPID_PS_RESET      4'h0

`endif

// ==== ppid_pkg.sv ====
// types shared by the pin interrupt block
// assumes nothing beyond the config header
package ppid_pkg;
    typedef struct packed {
        logic [3:0] pin_en;
        logic [3:0] polarity;
        logic       mode_lvl;
        logic       irq_en;
    } ppid_port_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ppid_apb_req_t;
endpackage

// ==== ppid_pin_src.sv ====
// external signal sources driving the two four-pin port groups
// assumes the bench sets the wanted levels; pins move on the clock edge
`timescale 1ns/1ns
`default_nettype none

module ppid_pin_src (
    input  wire logic       core_clk,
    input  wire logic [3:0] want_a,
    input  wire logic [3:0] want_b,
    output logic      [3:0] pin_a,
    output logic      [3:0] pin_b
);
    // pins launched on the bus clock, so every level is one full sample
    always_ff @(posedge core_clk) begin
        pin_a <= want_a;
        pin_b <= want_b;
    end
endmodule // ppid_pin_src

`default_nettype wire

// ==== port_pin_interrupt_detect_bench.sv ====
// self-checking bench for the pin interrupt block over apb
// assumes ppid_top, ppid_pin_src and the config header are compiled
`timescale 1ns/1ns
`include "ppid_cfg.svh"
`default_nettype none

module port_pin_interrupt_detect_bench;
    logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        wake_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pa, pb, pin_a, pin_b;
    logic [1:0]  port_irq_req;
    int          err_count, checks;

    ppid_top ppid_top_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a(pin_a),
        .pin_b(pin_b), .port_irq_req(port_irq_req), .wake_req(wake_req), .irq(irq));
    ppid_pin_src ppid_pin_src_i (.core_clk(core_clk), .want_a(pa), .want_b(pb),
        .pin_a(pin_a), .pin_b(pin_b));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
            err_count++;
        end
    endtask

    // one idle cycle after each transfer keeps drivers single per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask

    // outputs packed as {irq, wake_req, port_irq_req}, sampled settled
    task automatic outs(input logic [31:0] x);
        #1;
        chk({28'h0, irq, wake_req, port_irq_req}, x);
        @(posedge core_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    initial begin
        #100000;
        err_count++;
        test_done;
    end

    initial begin
        logic [31:0] q;
        logic e;
        err_count = 0;
        checks = 0;
        arst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pa = 4'hF;
        pb = 4'h0;
        tick(3);
        arst_n <= 1'b1;
        tick(3);
        for (int i = 0; i < 8; i++) begin
            rd(12'(4 * i), 32'h0);
        end
        outs(32'h0);
        apb(1'b0, 12'h024, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        wr(`PPID_OFF_PS_A, 32'h1);
        wr(`PPID_OFF_SC_A, 32'h2);
        pa <= 4'hB;
        tick(4);
        rd(`PPID_OFF_SC_A, 32'h2);
        pa <= 4'hA;
        tick(4);
        rd(`PPID_OFF_SC_A, 32'hA);
        outs(32'h5);
        wr(`PPID_OFF_SC_A, 32'h2);
        rd(`PPID_OFF_SC_A, 32'hA);
        wr(`PPID_OFF_SC_A, 32'h6);
        tick(3);
        rd(`PPID_OFF_SC_A, 32'h2);
        outs(32'h0);
        rd(`PPID_OFF_ISTAT, 32'h1);
        wr(`PPID_OFF_IEN, 32'h1);
        outs(32'h8);
        wr(`PPID_OFF_IEN, 32'h0);
        outs(32'h0);
        wr(`PPID_OFF_ICLR, 32'h1);
        rd(`PPID_OFF_ISTAT, 32'h0);
        wr(`PPID_OFF_IEN, 32'h3);
        wr(`PPID_OFF_ES_B, 32'h1);
        wr(`PPID_OFF_PS_B, 32'h1);
        wr(`PPID_OFF_SC_B, 32'h2);
        pb <= 4'h1;
        tick(4);
        rd(`PPID_OFF_SC_B, 32'hA);
        outs(32'hE);
        wr(`PPID_OFF_SC_B, 32'h6);
        rd(`PPID_OFF_SC_B, 32'h2);
        wr(`PPID_OFF_ICLR, 32'h3);
        outs(32'h0);
        wr(`PPID_OFF_SC_A, 32'h3);
        tick(3);
        rd(`PPID_OFF_SC_A, 32'hB);
        wr(`PPID_OFF_SC_A, 32'h7);
        tick(2);
        rd(`PPID_OFF_SC_A, 32'hB);
        pa <= 4'hF;
        tick(3);
        wr(`PPID_OFF_SC_A, 32'h7);
        tick(2);
        rd(`PPID_OFF_SC_A, 32'h3);
        wr(`PPID_OFF_ES_A, 32'h1);
        tick(3);
        rd(`PPID_OFF_SC_A, 32'hB);
        wr(`PPID_OFF_SC_B, 32'h3);
        tick(2);
        wr(`PPID_OFF_SC_B, 32'h7);
        rd(`PPID_OFF_SC_B, 32'hB);
        // mid-run reset must bring port A control and polarity back to defaults, outputs low
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(3);
        rd(`PPID_OFF_SC_A, 32'h0);
        rd(`PPID_OFF_ES_A, 32'h0);
        outs(32'h0);
        test_done;
    end
endmodule // port_pin_interrupt_detect_bench

`default_nettype wire
